// >>> rtl/rtcdar_regs.sv
// double-buffered day-of-month and alarm registers of the rtc
//
// What this block does
// - host writes land in a shadow copy; core takes it on write commit.
// - host copy reloads from core only while read refresh is set.
// - day register is 8 bits, day in bits 5:0, bits 7:6 reserved.
// - february allows 28 days, 29 when year divides by four.
// - alarm seconds value in bits 6:0, match enable in bit 7.
// - alarm minutes value in bits 6:0, match enable in bit 7.
// - enabled seconds equal to current seconds raises that alarm.
// - enabled minutes equal to current minutes raises that alarm.
// - counts count as valid only while day lies in 1 to 31.
`timescale 1ns/1ps
module rtcdar_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rtc_uvlo,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic write_commit_flag,
    input wire logic read_refresh_flag,
    input wire logic bcd_mode,
    input wire logic [7:0] cur_day,
    input wire logic [7:0] cur_month,
    input wire logic [7:0] cur_year,
    input wire logic [6:0] current_seconds_count,
    input wire logic [6:0] current_minutes_count,
    output logic day_load,
    output logic [7:0] day_load_value,
    output logic day_in_range,
    output logic [rtcdar_pkg::NUM_ALARMS-1:0] alarm_interrupt_x
);
    import rtcdar_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] addr_slot(input logic [7:0] a);
        case (a)
            OFS_DAY: addr_slot = SLOT_DAY;
            OFS_A1_SEC: addr_slot = SLOT_A1_SEC;
            OFS_A1_MIN: addr_slot = SLOT_A1_MIN;
            OFS_A2_SEC: addr_slot = SLOT_A2_SEC;
            OFS_A2_MIN: addr_slot = SLOT_A2_MIN;
            default: addr_slot = SLOT_NONE;
        endcase
    endfunction

    // value of a calendar field in plain binary, either format
    function automatic logic [6:0] to_bin(input logic [7:0] v,
                                          input logic bcd);
        logic [6:0] tens;
        tens = {3'h0, v[7:4]};
        if (bcd) begin
            to_bin = 7'(tens * 7'd10) + {3'h0, v[3:0]};
        end else begin
            to_bin = v[6:0];
        end
    endfunction

    function automatic logic [7:0] slot_mask(input logic [2:0] s);
        slot_mask = (s == SLOT_DAY) ? DAY_FIELD_MASK : FULL_MASK;
    endfunction

    function automatic logic [7:0] slot_reset(input logic [2:0] s);
        slot_reset = (s == SLOT_DAY) ? RST_DAY : RST_ALARM;
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // the backup-supply undervoltage clears everything, like reset
    wire clr = rst | rtc_uvlo;
    wire [2:0] acc_slot = addr_slot(reg_addr);
    wire acc_hit = (acc_slot != SLOT_NONE);
    wire host_wr = reg_wr & acc_hit;

    logic [7:0] host_q [NUM_SLOTS];
    logic [7:0] core_q [NUM_SLOTS];
    logic [7:0] reg_rdata_q;
    logic day_load_q;
    logic [7:0] day_load_value_q;
    logic day_in_range_q;

    // the core's day lives in the external counter, alarms live here
    logic [7:0] core_view [NUM_SLOTS];
    always_comb begin
        core_view[SLOT_DAY] = cur_day & DAY_FIELD_MASK;
        for (int i = 1; i < NUM_SLOTS; i++) begin
            core_view[i] = core_q[i];
        end
    end

    // ----------------------------------------------------------------
    // host copies and core copies
    // ----------------------------------------------------------------
    // a host write in the same cycle as a refresh wins, so no host
    // data is silently lost
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (clr) begin
                host_q[i] <= slot_reset(3'(i));
                core_q[i] <= slot_reset(3'(i));
            end else begin
                if (host_wr && acc_slot == 3'(i)) begin
                    host_q[i] <= reg_wdata & slot_mask(3'(i));
                end else if (read_refresh_flag) begin
                    host_q[i] <= core_view[i];
                end
                if (write_commit_flag) begin
                    core_q[i] <= host_q[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // day upload to the counter and read port
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (clr) begin
            day_load_q <= 1'b0;
            day_load_value_q <= RST_DAY;
            reg_rdata_q <= 8'h00;
        end else begin
            day_load_q <= write_commit_flag;
            if (write_commit_flag) begin
                day_load_value_q <= host_q[SLOT_DAY];
            end
            if (reg_rd) begin
                reg_rdata_q <= acc_hit ? host_q[acc_slot] : 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // calendar checks on the host's day value
    // ----------------------------------------------------------------
    wire [6:0] host_day = to_bin(host_q[SLOT_DAY], bcd_mode);
    wire [6:0] month_bin = to_bin(cur_month, bcd_mode);
    wire [6:0] year_bin = to_bin(cur_year, bcd_mode);
    // every fourth year is a leap year, no century exception
    wire leap = (year_bin[1:0] == 2'b00);
    wire short_month = (month_bin == MONTH_APR) ||
        (month_bin == MONTH_JUN) || (month_bin == MONTH_SEP) ||
        (month_bin == MONTH_NOV);
    wire [6:0] day_limit = (month_bin == MONTH_FEB) ?
        (leap ? DAY_MAX_FEB_LEAP : DAY_MAX_FEB) :
        (short_month ? DAY_MAX_SHORT : DAY_MAX_LONG);
    wire host_day_ok = (host_day >= DAY_MIN) && (host_day <= day_limit);

    // status only: the host owns the calendar's consistency
    always_ff @(posedge core_clk) begin
        if (clr) begin
            day_in_range_q <= 1'b1;
        end else begin
            day_in_range_q <= host_day_ok;
        end
    end

    // the running day, as the core sees it, gates the alarm counts
    wire [6:0] run_day = to_bin(cur_day & DAY_FIELD_MASK, bcd_mode);
    wire count_ok = (run_day >= DAY_MIN) && (run_day <= DAY_MAX_LONG);

    // ----------------------------------------------------------------
    // alarm comparators
    // ----------------------------------------------------------------
    rtcdar_alarm_if al_if [NUM_ALARMS] ();

    for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
        assign al_if[g].sec_reg = core_q[1 + 2 * g];
        assign al_if[g].min_reg = core_q[2 + 2 * g];
        assign al_if[g].cur_sec = current_seconds_count;
        assign al_if[g].cur_min = current_minutes_count;
        assign al_if[g].count_ok = count_ok;
        assign alarm_interrupt_x[g] = al_if[g].irq;
        rtcdar_alarm u_alarm (
            .core_clk(core_clk),
            .rst(clr),
            .al(al_if[g])
        );
    end

    assign reg_rdata = reg_rdata_q;
    assign day_load = day_load_q;
    assign day_load_value = day_load_value_q;
    assign day_in_range = day_in_range_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_commit_only: assert property (
        @(posedge core_clk) disable iff (clr)
        !write_commit_flag |=> $stable(core_q[SLOT_A1_SEC]) &&
            $stable(core_q[SLOT_A2_MIN]))
        else $error("core alarm changed without a commit");
    chk_commit_take: assert property (
        @(posedge core_clk) disable iff (clr)
        write_commit_flag |=> day_load &&
            core_q[SLOT_A1_MIN] == $past(host_q[SLOT_A1_MIN]) &&
            day_load_value == $past(host_q[SLOT_DAY]))
        else $error("commit did not move the shadow copy");
    chk_refresh_hold: assert property (
        @(posedge core_clk) disable iff (clr)
        (!read_refresh_flag && !host_wr) |=> $stable(host_q[SLOT_DAY]))
        else $error("host day changed without refresh or write");
    chk_refresh_load: assert property (
        @(posedge core_clk) disable iff (clr)
        (read_refresh_flag && !(host_wr && acc_slot == SLOT_A2_SEC))
        |=> host_q[SLOT_A2_SEC] == $past(core_q[SLOT_A2_SEC]))
        else $error("refresh did not reload the host copy");
    chk_rsvd_zero: assert property (
        @(posedge core_clk) disable iff (clr)
        reg_rd && acc_slot == SLOT_DAY |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved day bits read as non-zero");
    chk_feb_leap: assert property (
        @(posedge core_clk) disable iff (clr)
        (month_bin == MONTH_FEB && !leap && host_day == 7'd29)
        |=> !day_in_range)
        else $error("day 29 accepted in an ordinary february");
    chk_rsvd_dropped: assert property (
        @(posedge core_clk) disable iff (clr)
        host_q[SLOT_DAY][7:6] == 2'b00)
        else $error("reserved day bits held in the host copy");
    chk_write_lands: assert property (
        @(posedge core_clk) disable iff (clr)
        (host_wr && acc_slot == SLOT_A1_SEC)
        |=> host_q[SLOT_A1_SEC] == $past(reg_wdata))
        else $error("host write did not reach the shadow copy");
    chk_day_refresh: assert property (
        @(posedge core_clk) disable iff (clr)
        (read_refresh_flag && !(host_wr && acc_slot == SLOT_DAY))
        |=> host_q[SLOT_DAY] == ($past(cur_day) & DAY_FIELD_MASK))
        else $error("refresh did not reload the host day");
    chk_core_hold: assert property (
        @(posedge core_clk) disable iff (clr)
        !write_commit_flag |=> $stable(core_q[SLOT_A1_MIN]) &&
            $stable(core_q[SLOT_A2_SEC]))
        else $error("core alarm moved without a commit");
    chk_commit_rest: assert property (
        @(posedge core_clk) disable iff (clr)
        write_commit_flag |=>
            core_q[SLOT_A1_SEC] == $past(host_q[SLOT_A1_SEC]) &&
            core_q[SLOT_A2_SEC] == $past(host_q[SLOT_A2_SEC]) &&
            core_q[SLOT_A2_MIN] == $past(host_q[SLOT_A2_MIN]))
        else $error("commit left a core alarm behind");
    chk_load_pulse: assert property (
        @(posedge core_clk) disable iff (clr)
        !write_commit_flag |=> !day_load)
        else $error("day upload without a commit");
    chk_load_hold: assert property (
        @(posedge core_clk) disable iff (clr)
        !write_commit_flag |=> $stable(day_load_value))
        else $error("uploaded day changed without a commit");
    chk_load_value: assert property (
        @(posedge core_clk) disable iff (clr)
        day_load |-> day_load_value == $past(host_q[SLOT_DAY]))
        else $error("uploaded day differs from the shadow day");
    chk_read_copy: assert property (
        @(posedge core_clk) disable iff (clr)
        (reg_rd && acc_slot == SLOT_A1_MIN)
        |=> reg_rdata == $past(host_q[SLOT_A1_MIN]))
        else $error("read did not return the host copy");
    chk_rdata_hold: assert property (
        @(posedge core_clk) disable iff (clr)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_zero_day: assert property (
        @(posedge core_clk) disable iff (clr)
        cur_day[5:0] == 6'h00 |=> alarm_interrupt_x == '0)
        else $error("alarm raised on day zero");
    chk_alarms_apart: assert property (
        @(posedge core_clk) disable iff (clr)
        (core_q[SLOT_A1_SEC][6:0] != current_seconds_count &&
            !core_q[SLOT_A1_MIN][ALARM_EN_BIT])
        |=> !alarm_interrupt_x[0])
        else $error("alarm one raised without its own match");
    chk_sec_disabled: assert property (
        @(posedge core_clk) disable iff (clr)
        (!core_q[SLOT_A2_SEC][ALARM_EN_BIT] &&
            core_q[SLOT_A2_MIN][6:0] != current_minutes_count)
        |=> !alarm_interrupt_x[1])
        else $error("disabled seconds match raised alarm two");
    chk_clear_state: assert property (
        @(posedge core_clk)
        clr |=> host_q[SLOT_DAY] == RST_DAY &&
            core_q[SLOT_A1_SEC] == RST_ALARM && reg_rdata == 8'h00 &&
            !day_load && day_in_range)
        else $error("clear did not restore the reset values");
    chk_short_month: assert property (
        @(posedge core_clk) disable iff (clr)
        (month_bin == MONTH_APR && host_day == 7'h1f)
        |=> !day_in_range)
        else $error("day 31 accepted in a short month");
    chk_leap_feb: assert property (
        @(posedge core_clk) disable iff (clr)
        (month_bin == MONTH_FEB && leap && host_day == 7'h1d)
        |=> day_in_range)
        else $error("day 29 refused in a leap february");
endmodule

// >>> rtl/rtcdar_pkg.sv
// constants for the rtc day-of-month and alarm register block
package rtcdar_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DAY = 8'h0d;
    localparam logic [7:0] OFS_A1_SEC = 8'h0e;
    localparam logic [7:0] OFS_A1_MIN = 8'h0f;
    localparam logic [7:0] OFS_A2_SEC = 8'h15;
    localparam logic [7:0] OFS_A2_MIN = 8'h16;
    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic [7:0] DAY_FIELD_MASK = 8'h3f;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam int ALARM_EN_BIT = 7;
    localparam int NUM_SLOTS = 5;
    localparam int NUM_ALARMS = 2;
    // slot numbers inside the register array
    localparam logic [2:0] SLOT_DAY = 3'h0;
    localparam logic [2:0] SLOT_A1_SEC = 3'h1;
    localparam logic [2:0] SLOT_A1_MIN = 3'h2;
    localparam logic [2:0] SLOT_A2_SEC = 3'h3;
    localparam logic [2:0] SLOT_A2_MIN = 3'h4;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    // ----------------------------------------------------------------
    // calendar limits
    // ----------------------------------------------------------------
    localparam logic [6:0] DAY_MIN = 7'h01;
    localparam logic [6:0] DAY_MAX_LONG = 7'h1f;
    localparam logic [6:0] DAY_MAX_SHORT = 7'h1e;
    localparam logic [6:0] DAY_MAX_FEB = 7'h1c;
    localparam logic [6:0] DAY_MAX_FEB_LEAP = 7'h1d;
    localparam logic [6:0] MONTH_FEB = 7'h02;
    localparam logic [6:0] MONTH_APR = 7'h04;
    localparam logic [6:0] MONTH_JUN = 7'h06;
    localparam logic [6:0] MONTH_SEP = 7'h09;
    localparam logic [6:0] MONTH_NOV = 7'h0b;
endpackage

// >>> rtl/rtcdar_alarm_if.sv
// link between the register file and one alarm comparator
`timescale 1ns/1ps
interface rtcdar_alarm_if;
    logic [7:0] sec_reg;
    logic [7:0] min_reg;
    logic [6:0] cur_sec;
    logic [6:0] cur_min;
    logic count_ok;
    logic irq;
    modport regs (
        output sec_reg,
        output min_reg,
        output cur_sec,
        output cur_min,
        output count_ok,
        input irq
    );
    modport core (
        input sec_reg,
        input min_reg,
        input cur_sec,
        input cur_min,
        input count_ok,
        output irq
    );
endinterface

// >>> rtl/rtcdar_alarm.sv
// one alarm comparator: seconds and minutes match with enables
`timescale 1ns/1ps
module rtcdar_alarm (
    input wire logic core_clk,
    input wire logic rst,
    rtcdar_alarm_if.core al
);
    import rtcdar_pkg::*;

    // ----------------------------------------------------------------
    // match terms
    // ----------------------------------------------------------------
    wire sec_en = al.sec_reg[ALARM_EN_BIT];
    wire min_en = al.min_reg[ALARM_EN_BIT];
    wire sec_eq = (al.sec_reg[6:0] == al.cur_sec);
    wire min_eq = (al.min_reg[6:0] == al.cur_min);
    wire sec_hit = sec_en & sec_eq;
    wire min_hit = min_en & min_eq;
    // counts are ignored while the calendar day is out of range
    wire match_now = al.count_ok & (sec_hit | min_hit);

    logic match_q;
    logic irq_q;

    // a match that lasts a whole second raises only one pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            match_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            match_q <= match_now;
            irq_q <= match_now & ~match_q;
        end
    end

    assign al.irq = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_sec_raise: assert property (
        @(posedge core_clk) disable iff (rst)
        (sec_en && sec_eq && al.count_ok && !match_q) |=> irq_q)
        else $error("seconds match did not raise the alarm");
    chk_min_raise: assert property (
        @(posedge core_clk) disable iff (rst)
        (min_en && min_eq && al.count_ok && !match_q) |=> irq_q)
        else $error("minutes match did not raise the alarm");
    chk_enable_gates: assert property (
        @(posedge core_clk) disable iff (rst)
        irq_q |-> $past(sec_hit || min_hit))
        else $error("alarm raised without an enabled match");
    chk_bad_day: assert property (
        @(posedge core_clk) disable iff (rst)
        !al.count_ok |=> !irq_q)
        else $error("alarm raised while the day was invalid");
    chk_one_pulse: assert property (
        @(posedge core_clk) disable iff (rst)
        irq_q |=> !irq_q)
        else $error("alarm pulse held longer than one cycle");
endmodule

// >>> dv/rtcdar_rtc_model.sv
// behavioural rtc counter that faces the register block
`timescale 1ns/1ps
module rtcdar_rtc_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic day_load,
    input wire logic [7:0] day_load_value,
    output logic [7:0] cur_day,
    output logic [7:0] cur_month,
    output logic [7:0] cur_year,
    output logic [6:0] current_seconds_count,
    output logic [6:0] current_minutes_count
);
    logic [7:0] day_q;
    logic [7:0] month_q = 8'h01;
    logic [7:0] year_q = 8'h00;
    logic [6:0] sec_q = 7'h7f;
    logic [6:0] min_q = 7'h7f;
    // counts stay frozen so the bench can place exact match moments
    always @(posedge core_clk) begin
        if (rst) begin
            day_q <= 8'h01;
        end else if (day_load) begin
            day_q <= day_load_value;
        end
    end
    assign cur_day = day_q;
    assign cur_month = month_q;
    assign cur_year = year_q;
    assign current_seconds_count = sec_q;
    assign current_minutes_count = min_q;
endmodule

// >>> dv/rtcdar_regs_tb.sv
// self-checking bench for the rtc day and alarm register block
`timescale 1ns/1ps
module rtcdar_regs_tb;
    import rtcdar_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic rtc_uvlo = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic write_commit_flag = 1'b0;
    logic read_refresh_flag = 1'b0;
    logic bcd_mode = 1'b0;
    logic [7:0] reg_rdata, day_load_value, cur_day, cur_month, cur_year;
    logic [6:0] current_seconds_count, current_minutes_count;
    logic day_load, day_in_range;
    logic [1:0] alarm_interrupt_x;
    int failures = 0;
    int checks_done = 0;
    always #10 core_clk = ~core_clk;
    rtcdar_regs dut (.core_clk(core_clk), .rst(rst), .rtc_uvlo(rtc_uvlo),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .write_commit_flag(write_commit_flag),
        .read_refresh_flag(read_refresh_flag), .bcd_mode(bcd_mode),
        .cur_day(cur_day), .cur_month(cur_month), .cur_year(cur_year),
        .current_seconds_count(current_seconds_count),
        .current_minutes_count(current_minutes_count),
        .day_load(day_load), .day_load_value(day_load_value),
        .day_in_range(day_in_range), .alarm_interrupt_x(alarm_interrupt_x));
    rtcdar_rtc_model rtc (.core_clk(core_clk), .rst(rst),
        .day_load(day_load), .day_load_value(day_load_value),
        .cur_day(cur_day), .cur_month(cur_month), .cur_year(cur_year),
        .current_seconds_count(current_seconds_count),
        .current_minutes_count(current_minutes_count));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    task automatic commit(input logic [7:0] dv);
        @(posedge core_clk);
        write_commit_flag <= 1'b1;
        @(posedge core_clk);
        write_commit_flag <= 1'b0;
        #1 chk("day_load", {7'h00, day_load}, 8'h01);
        chk("day_load_value", day_load_value, dv);
        @(posedge core_clk);
        #1 chk("day_load end", {7'h00, day_load}, 8'h00);
    endtask
    // a pulse may come a little late, so the window spans four edges
    task automatic watch(input logic [6:0] s, m, input logic [1:0] e);
        logic [1:0] seen;
        seen = 2'b00;
        @(posedge core_clk);
        rtc.sec_q <= s;
        rtc.min_q <= m;
        repeat (4) begin
            @(posedge core_clk);
            #1 seen = seen | alarm_interrupt_x;
        end
        chk("alarm_interrupt_x", {6'h00, seen}, {6'h00, e});
    endtask
    task automatic rng(input logic [7:0] mo, yr, d, input logic e);
        @(posedge core_clk);
        rtc.month_q <= mo;
        rtc.year_q <= yr;
        wr(OFS_DAY, d);
        repeat (2) @(posedge core_clk);
        #1 chk("day_in_range", {7'h00, day_in_range}, {7'h00, e});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdc(OFS_DAY, RST_DAY);
        rdc(OFS_A1_SEC, RST_ALARM);
        rdc(OFS_A1_MIN, RST_ALARM);
        rdc(OFS_A2_SEC, RST_ALARM);
        rdc(OFS_A2_MIN, RST_ALARM);
        wr(8'h10, 8'h5a);
        rdc(8'h10, 8'h00);
        $display("test reset values done");
    endtask
    task automatic t_buffer();
        wr(OFS_DAY, 8'hc5);
        rdc(OFS_DAY, 8'h05);
        chk("cur_day", cur_day, 8'h01);
        commit(8'h05);
        chk("cur_day", cur_day, 8'h05);
        wr(OFS_DAY, 8'h07);
        wr(OFS_A1_SEC, 8'h33);
        rdc(OFS_DAY, 8'h07);
        @(posedge core_clk);
        read_refresh_flag <= 1'b1;
        @(posedge core_clk);
        read_refresh_flag <= 1'b0;
        rdc(OFS_DAY, 8'h05);
        rdc(OFS_A1_SEC, 8'h00);
        $display("test shadow buffering done");
    endtask
    task automatic t_alarm();
        wr(OFS_A1_SEC, 8'h85);
        wr(OFS_A2_MIN, 8'h8a);
        wr(OFS_A2_SEC, 8'h05);
        commit(8'h05);
        watch(7'h05, 7'h7f, 2'b01);
        watch(7'h7f, 7'h0a, 2'b10);
        watch(7'h7f, 7'h7f, 2'b00);
        watch(7'h05, 7'h0a, 2'b11);
        watch(7'h7f, 7'h7f, 2'b00);
        wr(OFS_DAY, 8'h09);
        commit(8'h09);
        // the counter side reports day zero; the host never writes it
        @(posedge core_clk);
        rtc.day_q <= 8'h00;
        watch(7'h05, 7'h0a, 2'b00);
        wr(OFS_DAY, 8'h05);
        commit(8'h05);
        watch(7'h7f, 7'h7f, 2'b00);
        watch(7'h05, 7'h0a, 2'b11);
        $display("test alarm match done");
    endtask
    task automatic t_range();
        rng(8'h02, 8'h01, 8'h1c, 1'b1);
        rng(8'h02, 8'h01, 8'h1d, 1'b0);
        rng(8'h02, 8'h04, 8'h1d, 1'b1);
        rng(8'h04, 8'h04, 8'h1f, 1'b0);
        rng(8'h0c, 8'h04, 8'h1f, 1'b1);
        @(posedge core_clk);
        bcd_mode <= 1'b1;
        rng(8'h12, 8'h24, 8'h31, 1'b1);
        rng(8'h02, 8'h24, 8'h29, 1'b1);
        rng(8'h02, 8'h23, 8'h29, 1'b0);
        $display("test day range done");
    endtask
    task automatic t_uvlo();
        wr(OFS_A2_SEC, 8'h85);
        @(posedge core_clk);
        rtc_uvlo <= 1'b1;
        @(posedge core_clk);
        rtc_uvlo <= 1'b0;
        rdc(OFS_A2_SEC, RST_ALARM);
        rdc(OFS_DAY, RST_DAY);
        $display("test undervoltage reset done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_buffer();
        t_alarm();
        t_range();
        t_uvlo();
        finish_test();
    end
    // the run needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        finish_test();
    end
endmodule
